// *** shared/aec_pkg.sv ***
package aec_pkg;

	// ****************************************************************
	// Widths, values after reset and counter limits.
	// ****************************************************************
	localparam int         CNT_W       = 8;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COUNT_MAX   = 8'hFF;
	localparam logic [7:0] COUNT_STEP  = 8'h01;

	// ****************************************************************
	// Register byte offsets on the bus.
	// ****************************************************************
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_HIGH = 4'h4;
	localparam logic [3:0] OFS_LOW  = 4'h8;
	localparam logic [3:0] OFS_IRQ  = 4'hC;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int BIT_OVH     = 7;
	localparam int BIT_OVL     = 6;
	localparam int BIT_IRQ_REQ = 0;
	localparam int BIT_IRQ_EN  = 1;
	localparam int CH_LOW      = 0;
	localparam int CH_HIGH     = 1;

	// ****************************************************************
	// Types.
	// ****************************************************************
	typedef struct packed {
		logic high_overflow_flag;
		logic low_overflow_flag;
		logic reserved;
		logic channel_split_select;
		logic high_count_enable;
		logic low_count_enable;
		logic high_reset_release;
		logic low_reset_release;
	} ctrl_status_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_resp_t;

	typedef enum logic [2:0] {
		MODE_ACTIVE,
		MODE_SLEEP,
		MODE_WATCH,
		MODE_SUBACTIVE,
		MODE_SUBSLEEP,
		MODE_STANDBY
	} power_mode_t;

endpackage : aec_pkg

// *** core/byte_counter.sv ***
`timescale 1ns/1ps
module byte_counter
	import aec_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             clear_i,
	input  wire logic             inc_i,
	output logic      [CNT_W-1:0] count_o,
	output logic                  wrap_o
);

	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;

	// Clear has priority so a held-in-reset counter never moves.
	always_comb begin
		count_nxt = count_r;
		if (clear_i) begin
			count_nxt = COUNT_RESET;
		end else if (inc_i) begin
			count_nxt = count_r + COUNT_STEP;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= COUNT_RESET;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign count_o = count_r;
	assign wrap_o  = inc_i & ~clear_i & (count_r == COUNT_MAX);

endmodule : byte_counter

// *** core/async_event_counter.sv ***
`timescale 1ns/1ps
module async_event_counter
	import aec_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        high_event_pin_i,
	input  wire logic        low_event_pin_i,
	input  wire power_mode_t power_mode_i,
	input  wire logic        module_standby_i,
	output logic             irq_o
);

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	ctrl_status_t     ctrl_r;
	ctrl_status_t     ctrl_nxt;
	logic             irq_req_r;
	logic             irq_req_nxt;
	logic             irq_en_r;
	logic             irq_en_nxt;
	wb_resp_t         resp_r;
	wb_resp_t         resp_nxt;
	logic [1:0]       pin_prev_r;
	logic [1:0]       pin_prev_nxt;
	logic [1:0]       pin_now;
	logic [1:0]       pin_rise;
	logic [1:0]       cnt_inc;
	logic [1:0]       cnt_clr;
	logic [1:0]       cnt_wrap;
	logic [CNT_W-1:0] cnt_val [1:0];
	logic             bus_req;
	logic             wr_fire;
	logic             wr_ctrl;
	logic             wr_irq;
	logic             hold_ctrl;
	logic             flags_quiet;
	logic             halted;
	logic             high_src;
	logic             ovl_set;
	logic             ovh_set;
	logic             irq_set;
	logic [31:0]      rd_data;

	// ****************************************************************
	// Power mode decode.
	// ****************************************************************
	// Watch and standby stop the CPU, so the control register is frozen
	// there; the counters themselves are never gated by the power mode.
	always_comb begin
		hold_ctrl   = module_standby_i;
		flags_quiet = 1'b0;
		case (power_mode_i)
			MODE_SLEEP: begin
				flags_quiet = 1'b1;
			end
			MODE_WATCH, MODE_STANDBY: begin
				hold_ctrl   = 1'b1;
				flags_quiet = 1'b1;
			end
			default: begin
				flags_quiet = 1'b0;
			end
		endcase
	end

	assign halted = module_standby_i;

	// ****************************************************************
	// Event pin edge detection.
	// ****************************************************************
	// The pins are taken as synchronous, so one stage of history is
	// enough to find a rising edge. Edges faster than half the clock
	// rate cannot be told apart and are lost.
	assign pin_now[CH_LOW]  = low_event_pin_i;
	assign pin_now[CH_HIGH] = high_event_pin_i;

	always_comb begin
		pin_prev_nxt = pin_now;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_prev_r <= 2'h0;
		end else begin
			pin_prev_r <= pin_prev_nxt;
		end
	end

	assign pin_rise = pin_now & ~pin_prev_r;

	// ****************************************************************
	// Count sources and gating.
	// ****************************************************************
	// In joined mode the high counter only sees low wraps, and only while
	// its own enable and release are set; software orders those bits.
	assign high_src = ctrl_r.channel_split_select ?
		pin_rise[CH_HIGH] : cnt_wrap[CH_LOW];

	assign cnt_inc[CH_LOW] = pin_rise[CH_LOW]
		& ctrl_r.low_count_enable
		& ctrl_r.low_reset_release
		& ~halted;

	assign cnt_inc[CH_HIGH] = high_src
		& ctrl_r.high_count_enable
		& ctrl_r.high_reset_release
		& ~halted;

	assign cnt_clr[CH_LOW]  = ~ctrl_r.low_reset_release;
	assign cnt_clr[CH_HIGH] = ~ctrl_r.high_reset_release;

	// ****************************************************************
	// Counter channels.
	// ****************************************************************
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			byte_counter u_cnt (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.clear_i (cnt_clr[ch]),
				.inc_i   (cnt_inc[ch]),
				.count_o (cnt_val[ch]),
				.wrap_o  (cnt_wrap[ch])
			);
		end
	endgenerate

	// ****************************************************************
	// Overflow detection.
	// ****************************************************************
	// A joined wrap of all sixteen bits shows only as a high wrap.
	assign ovl_set = ctrl_r.channel_split_select
		& cnt_wrap[CH_LOW] & ~flags_quiet;
	assign ovh_set = cnt_wrap[CH_HIGH] & ~flags_quiet;
	assign irq_set = ovl_set | ovh_set;

	// ****************************************************************
	// Bus handshake.
	// ****************************************************************
	// Ack comes one cycle after the request; the write lands on the edge
	// where the master sees ack, so a held request writes exactly once.
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign wr_fire = bus_req & wb_we_i & resp_r.ack & wb_sel_i[0];
	assign wr_ctrl = wr_fire & (wb_adr_i == OFS_CTRL);
	assign wr_irq  = wr_fire & (wb_adr_i == OFS_IRQ);

	always_comb begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
			OFS_CTRL: begin
				rd_data[CNT_W-1:0] = ctrl_r;
			end
			OFS_HIGH: begin
				rd_data[CNT_W-1:0] = cnt_val[CH_HIGH];
			end
			OFS_LOW: begin
				rd_data[CNT_W-1:0] = cnt_val[CH_LOW];
			end
			OFS_IRQ: begin
				rd_data[BIT_IRQ_REQ] = irq_req_r;
				rd_data[BIT_IRQ_EN]  = irq_en_r;
			end
			default: begin
				rd_data = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		resp_nxt.ack = bus_req & ~resp_r.ack;
		resp_nxt.dat = resp_r.dat;
		if (bus_req & ~resp_r.ack) begin
			resp_nxt.dat = rd_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resp_r <= '0;
		end else begin
			resp_r <= resp_nxt;
		end
	end

	assign wb_ack_o = resp_r.ack;
	assign wb_dat_o = resp_r.dat;

	// ****************************************************************
	// Control and status register.
	// ****************************************************************
	// Overflow flags clear only by writing zero; a set in the same cycle
	// wins so no overflow is lost.
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl & ~hold_ctrl) begin
			ctrl_nxt.channel_split_select = wb_dat_i[4];
			ctrl_nxt.high_count_enable    = wb_dat_i[3];
			ctrl_nxt.low_count_enable     = wb_dat_i[2];
			ctrl_nxt.high_reset_release   = wb_dat_i[1];
			ctrl_nxt.low_reset_release    = wb_dat_i[0];
			if (!wb_dat_i[BIT_OVH]) begin
				ctrl_nxt.high_overflow_flag = 1'b0;
			end
			if (!wb_dat_i[BIT_OVL]) begin
				ctrl_nxt.low_overflow_flag = 1'b0;
			end
		end
		if (ovh_set) begin
			ctrl_nxt.high_overflow_flag = 1'b1;
		end
		if (ovl_set) begin
			ctrl_nxt.low_overflow_flag = 1'b1;
		end
		ctrl_nxt.reserved = 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= ctrl_status_t'(CTRL_RESET);
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// ****************************************************************
	// Interrupt request and enable.
	// ****************************************************************
	always_comb begin
		irq_req_nxt = irq_req_r;
		irq_en_nxt  = irq_en_r;
		if (wr_irq) begin
			irq_en_nxt = wb_dat_i[BIT_IRQ_EN];
			if (!wb_dat_i[BIT_IRQ_REQ]) begin
				irq_req_nxt = 1'b0;
			end
		end
		if (irq_set) begin
			irq_req_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_req_r <= 1'b0;
			irq_en_r  <= 1'b0;
		end else begin
			irq_req_r <= irq_req_nxt;
			irq_en_r  <= irq_en_nxt;
		end
	end

	assign irq_o = irq_req_r & irq_en_r;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_single_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("Ack lasted more than one cycle.");

	ctrl_write_lands_a: assert property (
		wr_ctrl && !hold_ctrl |=>
			ctrl_r[4:0] == $past(wb_dat_i[4:0]))
		else $error("Control write did not take effect.");

	low_count_step_a: assert property (
		cnt_inc[CH_LOW] && !cnt_clr[CH_LOW] |=>
			cnt_val[CH_LOW] == CNT_W'($past(cnt_val[CH_LOW]) + COUNT_STEP))
		else $error("Low counter did not advance by one.");

	release_holds_zero_a: assert property (
		!ctrl_r.high_reset_release |=> cnt_val[CH_HIGH] == COUNT_RESET)
		else $error("High counter moved while held in reset.");

	joined_wrap_a: assert property (
		!ctrl_r.channel_split_select && cnt_inc[CH_LOW] &&
		cnt_val[CH_LOW] == COUNT_MAX && cnt_val[CH_HIGH] == COUNT_MAX &&
		cnt_inc[CH_HIGH] && !flags_quiet |=>
			ctrl_r.high_overflow_flag && cnt_val[CH_LOW] == COUNT_RESET &&
			cnt_val[CH_HIGH] == COUNT_RESET && irq_req_r)
		else $error("Joined sixteen-bit wrap misbehaved.");

	irq_gate_a: assert property (
		irq_set ##1 irq_en_r |-> irq_o)
		else $error("Enabled overflow did not raise the interrupt.");

	request_sticky_a: assert property (
		irq_req_r && !(wr_irq && !wb_dat_i[BIT_IRQ_REQ]) |=> irq_req_r)
		else $error("Interrupt request dropped without a clear.");

	quiet_flags_a: assert property (
		flags_quiet && !wr_ctrl |=>
			$stable(ctrl_r.high_overflow_flag) &&
			$stable(ctrl_r.low_overflow_flag))
		else $error("Overflow flag changed in a low-power mode.");

	standby_halt_a: assert property (
		module_standby_i && $past(module_standby_i) &&
		ctrl_r.low_reset_release |-> $stable(cnt_val[CH_LOW]) &&
			$stable(ctrl_r))
		else $error("Module standby did not halt the block.");

	split_low_flag_a: assert property (
		ctrl_r.channel_split_select && cnt_wrap[CH_LOW] && !flags_quiet
			|=> ctrl_r.low_overflow_flag && irq_req_r)
		else $error("Split low wrap did not flag overflow.");

	joined_overflow_c: cover property (
		!ctrl_r.channel_split_select && ovh_set);
	split_overflow_c: cover property (
		ctrl_r.channel_split_select && ovl_set);
	irq_raised_c: cover property (
		$rose(irq_o));
	quiet_count_c: cover property (
		flags_quiet && cnt_inc[CH_LOW]);

endmodule : async_event_counter

// *** test/event_source.sv ***
`timescale 1ns/1ps
module event_source (
	output logic high_event_pin_o,
	output logic low_event_pin_o,
	input  wire logic clk_i
);
	// ****************************************************************
	// Far side: two event sources that change pins after a clock edge.
	// ****************************************************************
	// Pins rest low between events. Each event is one high cycle and one
	// low cycle, the shortest pulse that the sampled inputs still resolve.
	initial begin
		high_event_pin_o = 1'b0;
		low_event_pin_o  = 1'b0;
	end

	task automatic pulse(input int n, input logic hi, input logic lo);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			high_event_pin_o <= hi;
			low_event_pin_o  <= lo;
			@(posedge clk_i);
			high_event_pin_o <= 1'b0;
			low_event_pin_o  <= 1'b0;
		end
		@(posedge clk_i);
	endtask : pulse
endmodule : event_source

// *** test/test_async_event_counter.sv ***
`timescale 1ns/1ps
module test_async_event_counter;
	import aec_pkg::*;
	// ****************************************************************
	// Bench signals and instances.
	// ****************************************************************
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [3:0]  wb_adr = 4'h0;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        hi_pin;
	logic        lo_pin;
	power_mode_t mode = MODE_ACTIVE;
	logic        stby = 1'b0;
	logic        irq_o;
	int          err_total = 0;
	int          total_checks = 0;

	always #12.5 clk_i = ~clk_i;

	event_source src (.high_event_pin_o(hi_pin), .low_event_pin_o(lo_pin),
		.clk_i(clk_i));

	async_event_counter dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.high_event_pin_i(hi_pin), .low_event_pin_i(lo_pin),
		.power_mode_i(mode), .module_standby_i(stby), .irq_o(irq_o));

	// ****************************************************************
	// Shared tasks.
	// ****************************************************************
	task automatic complete_run();
		if (err_total == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One classic cycle; request held until ack is sampled high.
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [7:0] d, input logic [3:0] s, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= w;
		wb_adr <= a;
		wb_sel <= s;
		wb_dat <= {24'h00_0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
		chk("bus ack", 8'h01, {7'h00, wb_ack_o});
	endtask : bus

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, 4'hF, q);
	endtask : wr

	task automatic rd(input string nm, input logic [3:0] a,
		input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, 4'hF, q);
		chk(nm, e, q);
	endtask : rd

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic t_reset();
		rd("ctrl", OFS_CTRL, 8'h00);
		rd("high", OFS_HIGH, 8'h00);
		rd("low", OFS_LOW, 8'h00);
		rd("irq", OFS_IRQ, 8'h00);
		rd("unmapped", 4'h2, 8'h00);
	endtask : t_reset

	task automatic t_joined();
		wr(OFS_CTRL, 8'h0F);
		src.pulse(257, 1'b1, 1'b1);
		wr(OFS_CTRL, 8'h03);
		rd("joined low", OFS_LOW, 8'h01);
		rd("joined high", OFS_HIGH, 8'h01);
		rd("joined ctrl", OFS_CTRL, 8'h03);
		rd("joined irq", OFS_IRQ, 8'h00);
	endtask : t_joined

	task automatic t_split();
		logic [7:0] q;
		wr(OFS_CTRL, 8'h00);
		wr(OFS_CTRL, 8'h1F);
		src.pulse(255, 1'b1, 1'b1);
		rd("split low", OFS_LOW, 8'hFF);
		rd("split high", OFS_HIGH, 8'hFF);
		rd("split irq", OFS_IRQ, 8'h00);
		src.pulse(1, 1'b1, 1'b1);
		rd("split ctrl", OFS_CTRL, 8'hDF);
		rd("wrap low", OFS_LOW, 8'h00);
		rd("wrap high", OFS_HIGH, 8'h00);
		rd("req", OFS_IRQ, 8'h01);
		chk("irq masked", 8'h00, {7'h00, irq_o});
		wr(OFS_IRQ, 8'h03);
		@(posedge clk_i);
		chk("irq on", 8'h01, {7'h00, irq_o});
		wr(OFS_IRQ, 8'h02);
		@(posedge clk_i);
		chk("irq off", 8'h00, {7'h00, irq_o});
		rd("req clr", OFS_IRQ, 8'h02);
		wr(OFS_CTRL, 8'h1F);
		bus(1'b1, OFS_CTRL, 8'h00, 4'hE, q);
		rd("flag clr", OFS_CTRL, 8'h1F);
	endtask : t_split

	task automatic t_halt();
		wr(OFS_CTRL, 8'h17);
		src.pulse(3, 1'b1, 1'b1);
		rd("halt high", OFS_HIGH, 8'h00);
		rd("run low", OFS_LOW, 8'h03);
		wr(OFS_CTRL, 8'h1E);
		src.pulse(2, 1'b1, 1'b1);
		rd("held low", OFS_LOW, 8'h00);
		rd("free high", OFS_HIGH, 8'h02);
	endtask : t_halt

	task automatic t_modes();
		power_mode_t ml[5];
		logic        quiet;
		logic        hold;
		ml = '{MODE_SLEEP, MODE_WATCH, MODE_SUBACTIVE, MODE_SUBSLEEP,
			MODE_STANDBY};
		foreach (ml[i]) begin
			quiet = ml[i] inside {MODE_SLEEP, MODE_WATCH, MODE_STANDBY};
			hold  = ml[i] inside {MODE_WATCH, MODE_STANDBY};
			@(posedge clk_i);
			mode <= MODE_ACTIVE;
			wr(OFS_CTRL, 8'h00);
			wr(OFS_CTRL, 8'h1F);
			wr(OFS_IRQ, 8'h02);
			@(posedge clk_i);
			mode <= ml[i];
			src.pulse(257, 1'b1, 1'b1);
			rd("mode low", OFS_LOW, 8'h01);
			rd("mode high", OFS_HIGH, 8'h01);
			rd("mode ctrl", OFS_CTRL, quiet ? 8'h1F : 8'hDF);
			rd("mode irq", OFS_IRQ, quiet ? 8'h02 : 8'h03);
			wr(OFS_CTRL, 8'h00);
			rd("mode hold", OFS_CTRL, hold ? (quiet ? 8'h1F : 8'hDF)
				: 8'h00);
		end
		@(posedge clk_i);
		mode <= MODE_ACTIVE;
	endtask : t_modes

	task automatic t_standby();
		wr(OFS_CTRL, 8'h00);
		wr(OFS_CTRL, 8'h1F);
		src.pulse(2, 1'b1, 1'b1);
		@(posedge clk_i);
		stby <= 1'b1;
		src.pulse(3, 1'b1, 1'b1);
		wr(OFS_CTRL, 8'h00);
		rd("stby low", OFS_LOW, 8'h02);
		rd("stby high", OFS_HIGH, 8'h02);
		rd("stby ctrl", OFS_CTRL, 8'h1F);
		@(posedge clk_i);
		stby <= 1'b0;
	endtask : t_standby

	// The high byte is filled from its own pin in split mode first, so the
	// sixteen-bit wrap is reached in a few hundred events, not 65,536.
	task automatic t_wrap16();
		wr(OFS_CTRL, 8'h00);
		wr(OFS_IRQ, 8'h02);
		wr(OFS_CTRL, 8'h1F);
		src.pulse(255, 1'b1, 1'b0);
		rd("pre high", OFS_HIGH, 8'hFF);
		wr(OFS_CTRL, 8'h0F);
		src.pulse(255, 1'b0, 1'b1);
		rd("pre low", OFS_LOW, 8'hFF);
		rd("pre ctrl", OFS_CTRL, 8'h0F);
		src.pulse(1, 1'b0, 1'b1);
		rd("wrap16 ctrl", OFS_CTRL, 8'h8F);
		rd("wrap16 low", OFS_LOW, 8'h00);
		rd("wrap16 high", OFS_HIGH, 8'h00);
		rd("wrap16 irq", OFS_IRQ, 8'h03);
		chk("wrap16 irq_o", 8'h01, {7'h00, irq_o});
		src.pulse(1, 1'b0, 1'b1);
		rd("wrap16 again", OFS_LOW, 8'h01);
	endtask : t_wrap16

	// A full run takes some 5,000 cycles; the limit leaves wide room.
	initial begin
		repeat (40000) @(posedge clk_i);
		err_total++;
		complete_run();
	end

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_joined();
		t_split();
		t_halt();
		t_modes();
		t_standby();
		t_wrap16();
		complete_run();
	end
endmodule : test_async_event_counter
